// ==== logic/rtc_defines.vh ====
// Constants for the radio transmit/receive and CSMA control register bank
// Function
// - Filter enable applies first-address filtering
// - Coordinator bit counts coordinator address match
// - Level filter accepts only above threshold
// - Save-bank select picks status bank read
// - Overwrite off protects full RAM bank
// - Extension bit adds PAN/second address condition
// - General-mode bit suppresses unicast output when set
// - Read-only save bank pointer, resets 02H
// - Receive trigger: warm-up, ready after 185us
// - Transmit trigger: warm-up, transmit after 335us
// - Assess trigger: warm-up 185us, min exponent nonzero
// - Trigger bits self-clear when operation completes
// - Auto-ack-receive bit enables ack reception
// - Trigger bits write-only, ack bit readable
// - CSMA start bit launches, self-clears only
// - Transmit after CSMA when channel clear
// - Receive during CSMA pauses backoff counting
// - Unicast value only used when enabled
// - Post-CSMA mode minimises wait when set
// - Capture banks at reception start, reset 03H
// - RAM bank full flag set at completion
// - Overrun when writing into full bank
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH
`define RTC_ADDR_W        8
`define RTC_OFS_FILTER    8'h0A
`define RTC_OFS_TRIG      8'h0C
`define RTC_OFS_CSMA      8'h0D
`define RTC_OFS_STARTFLG  8'h10
`define RTC_OFS_PTRSTAT   8'h0E
`define RTC_OFS_RAMSTAT   8'h0F
`define RTC_OFS_BACKOFF   8'h14
`define RTC_RST_FILTER    8'h00
`define RTC_RST_TRIG      8'h00
`define RTC_RST_CSMA      8'h00
`define RTC_RST_STARTFLG  2'h3
`define RTC_RST_PTR       1'h1
`define RTC_RST_BACKOFF   3'h3
`define RTC_BIT_RX        0
`define RTC_BIT_TX        1
`define RTC_BIT_CCA       2
`define RTC_BIT_ACK       3
`define RTC_BIT_ADRF      0
`define RTC_BIT_CORD      1
`define RTC_BIT_LVLF      2
`define RTC_BIT_BSEL      4
`define RTC_BIT_OVW       5
`define RTC_BIT_EXT       6
`define RTC_BIT_GEN       7
`define RTC_BIT_CSST      0
`define RTC_BIT_CSTX      1
`define RTC_BIT_CSRX      2
`define RTC_BIT_UNI       4
`define RTC_BIT_CSMODE    5
`define RTC_CLK_MHZ       250
`define RTC_RX_WARM_US    185
`define RTC_TX_WARM_US    335
`define RTC_CCA_WARM_US   185
`define RTC_RX_WARM_CYC   (`RTC_RX_WARM_US * `RTC_CLK_MHZ)
`define RTC_TX_WARM_CYC   (`RTC_TX_WARM_US * `RTC_CLK_MHZ)
`define RTC_CCA_WARM_CYC  (`RTC_CCA_WARM_US * `RTC_CLK_MHZ)
`define RTC_CNT_W         17
`endif

// ==== logic/rtc_radio_ctrl.v ====
// Register bank and trigger sequencing for radio transmit, receive and CSMA-CA
`timescale 1ns/1ps
`include "rtc_defines.vh"
module rtc_radio_ctrl #(
  parameter RX_WARM_CYC  = `RTC_RX_WARM_CYC,
  parameter TX_WARM_CYC  = `RTC_TX_WARM_CYC,
  parameter CCA_WARM_CYC = `RTC_CCA_WARM_CYC
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        rxStart,
  input  wire        rxDone,
  input  wire        rxAddrMatch1,
  input  wire        rxCoordMatch,
  input  wire        rxSecondMatch,
  input  wire        rxLevelOk,
  input  wire        txDone,
  input  wire        ccaDone,
  input  wire        ccaBusy,
  input  wire        csmaDone,
  input  wire        stopComm,
  output reg         rxWarmup,
  output reg         rxReady,
  output reg         txWarmup,
  output reg         txActive,
  output reg         ccaWarmup,
  output reg         ccaActive,
  output reg         csmaRun,
  output reg         csmaAutoTx,
  output reg         backoffPause,
  output reg         rxAccept,
  output reg         rxRamWrite,
  output reg         rxOverrun,
  output reg         unicastOut,
  output reg         minWaitTx,
  output reg         autoAckRx,
  output reg         idle
);

  // ==========================================================
  // Input synchronisers: three stages, change on 2nd/3rd agree
  // ==========================================================
  localparam NIN = 11;
  wire [NIN-1:0] rawIn = {stopComm, csmaDone, ccaBusy, ccaDone, txDone, rxLevelOk,
                          rxSecondMatch, rxCoordMatch, rxAddrMatch1, rxDone, rxStart};
  reg  [NIN-1:0] s1Reg;
  reg  [NIN-1:0] s2Reg;
  reg  [NIN-1:0] s3Reg;
  reg  [NIN-1:0] inReg;
  reg  [NIN-1:0] inPrevReg;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1)
    begin : g_sync
      always @(posedge sys_clk)
      begin
        if (rst)
        begin
          s1Reg[gi]     <= 1'b0;
          s2Reg[gi]     <= 1'b0;
          s3Reg[gi]     <= 1'b0;
          inReg[gi]     <= 1'b0;
          inPrevReg[gi] <= 1'b0;
        end
        else
        begin
          s1Reg[gi]     <= rawIn[gi];
          s2Reg[gi]     <= s1Reg[gi];
          s3Reg[gi]     <= s2Reg[gi];
          if (s2Reg[gi] == s3Reg[gi])
            inReg[gi]   <= s3Reg[gi];
          inPrevReg[gi] <= inReg[gi];
        end
      end
    end
  endgenerate
  wire [NIN-1:0] rise = inReg & ~inPrevReg;
  wire evRxStart  = rise[0];
  wire evRxDone   = rise[1];
  wire addrMatch1 = inReg[2];
  wire coordMatch = inReg[3];
  wire secondMatch = inReg[4];
  wire levelOk    = inReg[5];
  wire evTxDone   = rise[6];
  wire evCcaDone  = rise[7];
  wire chanBusy   = inReg[8];
  wire evCsmaDone = rise[9];
  wire evStop     = rise[10];

  // ==========================================================
  // Registers and Avalon slave
  // ==========================================================
  reg  [7:0]  filterModeReg;
  reg  [7:0]  csmaCtrlReg;
  reg         rxTrigReg;
  reg         txTrigReg;
  reg         ccaTrigReg;
  reg         ackRxReg;
  reg  [2:0]  minBackoffExpReg;
  reg         savePtrReg;
  reg  [1:0]  startFlagReg;
  reg         ramPtrReg;
  reg  [1:0]  ramFullReg;
  reg  [1:0]  saveCrcReg;
  reg  [NIN-1:0] unusedReg;
  reg  [`RTC_CNT_W-1:0] warmCntReg;

  reg  answeredReg;
  wire access = avs_read | avs_write;
  assign avs_waitrequest = access & ~answeredReg;
  wire wrTake = avs_write & answeredReg & avs_byteenable[0];
  wire rdTake = avs_read & answeredReg;
  wire [7:0] wd = avs_writedata[7:0];

  always @(posedge sys_clk)
  begin
    if (rst)
      answeredReg <= 1'b0;
    else
      answeredReg <= access & ~answeredReg;
  end

  reg [7:0] rdMux;
  always @*
  begin
    rdMux = 8'h00;
    case (avs_address)
      `RTC_OFS_FILTER:   rdMux = filterModeReg;
      `RTC_OFS_TRIG:     rdMux = {4'h0, ackRxReg, 3'h0};
      `RTC_OFS_CSMA:     rdMux = {csmaCtrlReg[7:1], 1'b0};
      `RTC_OFS_STARTFLG: rdMux = {6'h00, startFlagReg};
      `RTC_OFS_PTRSTAT:  rdMux = {6'h00, savePtrReg, 1'b0};
      `RTC_OFS_RAMSTAT:  rdMux = {4'h0, saveCrcReg[filterModeReg[`RTC_BIT_BSEL]],
                                 ramPtrReg, ramFullReg};
      `RTC_OFS_BACKOFF:  rdMux = {5'h00, minBackoffExpReg};
      default:           rdMux = 8'h00;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~answeredReg)
      avs_readdata <= {24'h000000, rdMux};
  end

  // ==========================================================
  // Radio sequencer
  // ==========================================================
  localparam ST_IDLE  = 6'h01;
  localparam ST_RXW   = 6'h02;
  localparam ST_RX    = 6'h04;
  localparam ST_TXW   = 6'h08;
  localparam ST_TX    = 6'h10;
  localparam ST_CCA   = 6'h20;
  reg [5:0] stateReg;

  wire isIdle = stateReg == ST_IDLE;
  wire trigWr = wrTake & (avs_address == `RTC_OFS_TRIG);
  wire csmaWr = wrTake & (avs_address == `RTC_OFS_CSMA);
  wire ramWrite = evRxStart & rxAccept;
  wire targetFull = ramFullReg[ramPtrReg];

  always @*
  begin
    csmaRun      = csmaCtrlReg[`RTC_BIT_CSST];
    rxAccept = ~(filterModeReg[`RTC_BIT_ADRF] &
               ~(addrMatch1 | (filterModeReg[`RTC_BIT_CORD] & coordMatch)))
               & ~(filterModeReg[`RTC_BIT_ADRF] & filterModeReg[`RTC_BIT_EXT]
                   & ~secondMatch)
               & ~(filterModeReg[`RTC_BIT_LVLF] & ~levelOk)
               & (stateReg == ST_RX | (csmaRun & csmaCtrlReg[`RTC_BIT_CSRX]));
    rxRamWrite   = ramWrite & (filterModeReg[`RTC_BIT_OVW] | ~targetFull);
    backoffPause = csmaRun & csmaCtrlReg[`RTC_BIT_CSRX] & inReg[0];
    unicastOut   = csmaCtrlReg[`RTC_BIT_UNI] & ~filterModeReg[`RTC_BIT_GEN];
    minWaitTx    = csmaCtrlReg[`RTC_BIT_CSMODE];
    autoAckRx    = ackRxReg;
    idle         = isIdle & ~csmaRun;
    rxWarmup     = stateReg == ST_RXW;
    rxReady      = stateReg == ST_RX;
    txWarmup     = stateReg == ST_TXW;
    txActive     = stateReg == ST_TX;
    ccaWarmup    = ccaTrigReg & (stateReg == ST_CCA) & (warmCntReg != 0);
    ccaActive    = (stateReg == ST_CCA) & (warmCntReg == 0);
    csmaAutoTx   = evCsmaDone & csmaCtrlReg[`RTC_BIT_CSTX] & ~chanBusy;
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      stateReg      <= ST_IDLE;
      filterModeReg <= `RTC_RST_FILTER;
      csmaCtrlReg   <= `RTC_RST_CSMA;
      rxTrigReg     <= 1'b0;
      txTrigReg     <= 1'b0;
      ccaTrigReg    <= 1'b0;
      ackRxReg      <= 1'b0;
      minBackoffExpReg <= `RTC_RST_BACKOFF;
      savePtrReg    <= `RTC_RST_PTR;
      startFlagReg  <= `RTC_RST_STARTFLG;
      ramPtrReg     <= 1'b1;
      ramFullReg    <= 2'h0;
      saveCrcReg    <= 2'h0;
      warmCntReg    <= {`RTC_CNT_W{1'b0}};
      rxOverrun     <= 1'b0;
      unusedReg     <= {NIN{1'b0}};
    end
    else
    begin
      unusedReg <= {NIN{1'b0}};
      rxOverrun <= ramWrite & targetFull;
      if (wrTake & (avs_address == `RTC_OFS_FILTER))
        filterModeReg <= {wd[7:4], 1'b0, wd[2:0]};
      if (wrTake & (avs_address == `RTC_OFS_BACKOFF))
        minBackoffExpReg <= wd[2:0];
      if (trigWr)
        ackRxReg <= wd[`RTC_BIT_ACK];
      if (ramWrite)
      begin
        startFlagReg <= {savePtrReg, ramPtrReg};
      end
      // RAM full flags: hardware set wins over software clear
      if (wrTake & (avs_address == `RTC_OFS_RAMSTAT))
        ramFullReg <= ramFullReg & wd[1:0];
      if (evRxDone & rxAccept & (filterModeReg[`RTC_BIT_OVW] | ~targetFull))
      begin
        ramFullReg[ramPtrReg] <= 1'b1;
        saveCrcReg[savePtrReg] <= 1'b0;
        ramPtrReg  <= ~ramPtrReg;
        savePtrReg <= ~savePtrReg;
      end
      // CSMA control: start bit set only by writing 1, cleared only by hardware
      if (csmaWr)
        csmaCtrlReg <= {2'h0, wd[5:4], 1'b0, wd[2:1],
                        csmaCtrlReg[`RTC_BIT_CSST] | (wd[`RTC_BIT_CSST] & isIdle)};
      if (evCsmaDone | evStop)
        csmaCtrlReg[`RTC_BIT_CSST] <= 1'b0;
      case (stateReg)
        ST_IDLE:
        begin
          // Writes of 0 leave triggers alone; only 1 starts an operation
          if (trigWr & wd[`RTC_BIT_RX] & ~csmaRun)
          begin
            rxTrigReg  <= 1'b1;
            warmCntReg <= RX_WARM_CYC[`RTC_CNT_W-1:0];
            stateReg   <= ST_RXW;
          end
          else if ((trigWr & wd[`RTC_BIT_TX] & ~csmaRun) | csmaAutoTx)
          begin
            txTrigReg  <= 1'b1;
            warmCntReg <= TX_WARM_CYC[`RTC_CNT_W-1:0];
            stateReg   <= ST_TXW;
          end
          else if (trigWr & wd[`RTC_BIT_CCA] & ~csmaRun & (minBackoffExpReg != 3'h0))
          begin
            ccaTrigReg <= 1'b1;
            warmCntReg <= CCA_WARM_CYC[`RTC_CNT_W-1:0];
            stateReg   <= ST_CCA;
          end
        end
        ST_RXW:
        begin
          warmCntReg <= warmCntReg - 1'b1;
          if (warmCntReg == 1)
            stateReg <= ST_RX;
          if (evStop)
          begin
            rxTrigReg <= 1'b0;
            stateReg  <= ST_IDLE;
          end
        end
        ST_RX:
        begin
          if (evRxDone | evStop)
          begin
            rxTrigReg <= 1'b0;
            stateReg  <= ST_IDLE;
          end
        end
        ST_TXW:
        begin
          warmCntReg <= warmCntReg - 1'b1;
          if (warmCntReg == 1)
            stateReg <= ST_TX;
        end
        ST_TX:
        begin
          if (evTxDone)
          begin
            txTrigReg <= 1'b0;
            stateReg  <= ST_IDLE;
          end
        end
        ST_CCA:
        begin
          if (warmCntReg != 0)
            warmCntReg <= warmCntReg - 1'b1;
          if (evCcaDone | evStop)
          begin
            ccaTrigReg <= 1'b0;
            stateReg   <= ST_IDLE;
          end
        end
        default:
          stateReg <= ST_IDLE;
      endcase
    end
  end

endmodule // rtc_radio_ctrl

// ==== sim/rtc_radio_ctrl_asserts.sv ====
// Port-level assertions for the radio control register bank
`timescale 1ns/1ps
module rtc_radio_ctrl_asserts #(
  parameter RX_WARM_CYC  = 8,
  parameter TX_WARM_CYC  = 12,
  parameter CCA_WARM_CYC = 8
) (
  input wire        sys_clk,
  input wire        rst,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        rxWarmup,
  input wire        rxReady,
  input wire        txWarmup,
  input wire        txActive,
  input wire        ccaWarmup,
  input wire        ccaActive,
  input wire        autoAckRx
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire rdTaken = avs_read && !avs_waitrequest;
  // ==========================================
  // Bus answers, readback and ack output
  wait_one_a: assert property (($rose(avs_read) || $rose(avs_write)) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer not one cycle");
  rd_upper_a: assert property (rdTaken |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read lanes nonzero");
  trig_rd_a: assert property (rdTaken && avs_address == 8'h0C
    |-> avs_readdata[2:0] == 3'h0) else $error("trigger bits readable");
  csma_rd_a: assert property (rdTaken && avs_address == 8'h0D
    |-> avs_readdata[0] == 1'b0) else $error("csma start bit readable");
  ack_out_a: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
    && avs_address == 8'h0C |=> autoAckRx == $past(avs_writedata[3]))
    else $error("ack receive output wrong");
  // ==========================================
  // Warm-up lengths
  rx_warm_a: assert property ($rose(rxWarmup) |->
    (rxWarmup && !rxReady)[*6] ##[1:6] rxReady) else $error("rx warm-up length");
  tx_warm_a: assert property ($rose(txWarmup) |->
    (txWarmup && !txActive)[*8] ##[1:8] txActive) else $error("tx warm-up length");
  cca_warm_a: assert property ($rose(ccaWarmup) |->
    (ccaWarmup && !ccaActive)[*6] ##[1:6] ccaActive) else $error("cca warm-up length");
endmodule // rtc_radio_ctrl_asserts

bind rtc_radio_ctrl rtc_radio_ctrl_asserts #(
  .RX_WARM_CYC  (RX_WARM_CYC),
  .TX_WARM_CYC  (TX_WARM_CYC),
  .CCA_WARM_CYC (CCA_WARM_CYC)
) chk (.*);

// ==== sim/rtc_radio_model.sv ====
// Radio front end and channel peers answering the control block
`timescale 1ns/1ps
module rtc_radio_model (
  input  wire  sys_clk,
  input  wire  rst,
  input  wire  slowMode,
  input  wire  rxReady,
  input  wire  txActive,
  input  wire  ccaActive,
  input  wire  csmaRun,
  output logic rxStart,
  output logic rxDone,
  output logic txDone,
  output logic ccaDone,
  output logic csmaDone,
  output logic ccaBusy,
  output logic stopComm,
  output logic rxAddrMatch1,
  output logic rxCoordMatch,
  output logic rxSecondMatch,
  output logic rxLevelOk
);
  logic [7:0] cnt;
  logic       inFrame;
  wire  [7:0] dly  = slowMode ? 8'h28 : 8'h0A;
  wire  [7:0] dly2 = {dly[6:0], 1'b0};
  wire        win  = (cnt == dly) || (cnt == dly + 8'h01);
  wire        busy = rxReady | inFrame | txActive | ccaActive | csmaRun;
  // ==========================================
  // Answer each operation after a prompt or slow delay
  always @(posedge sys_clk)
  begin
    if (rst || !busy)
      cnt <= 8'h00;
    else if (cnt != 8'hFF)
      cnt <= cnt + 8'h01;
    if (rst || cnt == dly2 + 8'h02)
      inFrame <= 1'b0;
    else if (rxStart)
      inFrame <= 1'b1;
  end
  assign rxStart       = rxReady & win;
  assign rxDone        = inFrame & ((cnt == dly2) || (cnt == dly2 + 8'h01));
  assign txDone        = txActive & win;
  assign ccaDone       = ccaActive & win;
  assign csmaDone      = csmaRun & win;
  assign ccaBusy       = 1'b0;
  assign stopComm      = 1'b0;
  assign rxAddrMatch1  = 1'b1;
  assign rxCoordMatch  = 1'b0;
  assign rxSecondMatch = 1'b1;
  assign rxLevelOk     = 1'b1;
endmodule // rtc_radio_model

// ==== sim/tb.sv ====
// Self-checking bench for the radio control register bank
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); fails++; end end
`define WAITON(c) begin n = 0; while (!(c) && n < 400) begin @(posedge sys_clk); n++; end end
module tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, slowMode = 1'b0, sawOvr = 1'b0;
  logic        rxStart, rxDone, rxAddrMatch1, rxCoordMatch, rxSecondMatch, rxLevelOk;
  logic        txDone, ccaDone, ccaBusy, csmaDone, stopComm, rxWarmup, rxReady, txWarmup;
  logic        txActive, ccaWarmup, ccaActive, csmaRun, csmaAutoTx, backoffPause, rxAccept;
  logic        rxRamWrite, rxOverrun, unicastOut, minWaitTx, autoAckRx, idle;
  integer      fails = 0, testsRun = 0, cycles = 0, n, wrCnt = 0, wrBase = 0;
  rtc_radio_ctrl #(.RX_WARM_CYC(8), .TX_WARM_CYC(12), .CCA_WARM_CYC(8)) dut (.*);
  rtc_radio_model model (.*);
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    sawOvr <= sawOvr | (rxOverrun === 1'b1);
    if (rxRamWrite === 1'b1)
      wrCnt <= wrCnt + 1;
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      wrapUp();
    end
  end
  // ==========================================
  // Bus access, frame reception and closing tasks
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic wr, output logic [7:0] q);
    integer k;
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      do begin @(posedge sys_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(a, d, 1'b1, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] q;
    begin
      acc(a, 8'h00, 1'b0, q);
      `CHK($sformatf("reg %h", a), e, q & m)
    end
  endtask
  task wrapUp;
    begin
      $display("comparisons %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task rxFrame;
    begin
      wr(8'h0C, 8'h09);
      `WAITON(rxReady)
      repeat (2) @(posedge sys_clk);
      `WAITON(idle)
      `CHK("idle", 1'b1, idle)
    end
  endtask
  // ==========================================
  // Test sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(8'h0A, 8'h00, 8'hFF);
    rdc(8'h0C, 8'h00, 8'hFF);
    rdc(8'h0D, 8'h00, 8'hFF);
    rdc(8'h10, 8'h03, 8'hFF);
    rdc(8'h0E, 8'h02, 8'hFF);
    wr(8'h20, 8'hFF);
    rdc(8'h20, 8'h00, 8'hFF);
    wr(8'h10, 8'h00);
    rdc(8'h10, 8'h03, 8'hFF);
    wr(8'h0A, 8'hFF);
    rdc(8'h0A, 8'hF7, 8'hFF);
    wr(8'h0A, 8'h00);
    rxFrame();
    rdc(8'h0C, 8'h08, 8'hFF);
    `CHK("autoAckRx", 1'b1, autoAckRx)
    rdc(8'h0E, 8'h00, 8'h02);
    rdc(8'h0F, 8'h02, 8'h07);
    slowMode <= 1'b1;
    rxFrame();
    rdc(8'h10, 8'h00, 8'hFF);
    rdc(8'h0F, 8'h07, 8'h07);
    wrBase = wrCnt;
    rxFrame();
    `CHK("overrun", 1'b1, sawOvr)
    `CHK("ramWrite", 0, wrCnt - wrBase)
    wr(8'h0F, 8'h00);
    rdc(8'h0F, 8'h00, 8'h03);
    slowMode <= 1'b0;
    wr(8'h0C, 8'h02);
    wr(8'h0C, 8'h00);
    `CHK("txWarmup", 1'b1, txWarmup)
    wr(8'h0C, 8'h01);
    repeat (2) @(posedge sys_clk);
    `CHK("rxWarmup", 1'b0, rxWarmup)
    `WAITON(txActive)
    `WAITON(idle)
    wr(8'h14, 8'h00);
    wr(8'h0C, 8'h04);
    repeat (2) @(posedge sys_clk);
    `CHK("ccaWarmup", 1'b0, ccaWarmup)
    wr(8'h14, 8'h03);
    wr(8'h0C, 8'h04);
    repeat (2) @(posedge sys_clk);
    `CHK("ccaWarmup", 1'b1, ccaWarmup)
    `WAITON(idle)
    wr(8'h0D, 8'h20);
    @(posedge sys_clk);
    `CHK("minWaitTx", 1'b1, minWaitTx)
    slowMode <= 1'b1;
    wr(8'h0D, 8'h03);
    rdc(8'h0D, 8'h02, 8'hFF);
    wr(8'h0D, 8'h02);
    `CHK("csmaRun", 1'b1, csmaRun)
    `CHK("minWaitTx", 1'b0, minWaitTx)
    `WAITON(txActive)
    `CHK("txActive", 1'b1, txActive)
    `WAITON(idle)
    wrapUp();
  end
endmodule // tb
